// ===== rtl/burst_sram_regs.svh
// constants for the pipelined burst sram block
`ifndef BURST_SRAM_REGS_SVH
`define BURST_SRAM_REGS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define BSR_ADDR_W 18
`define BSR_UPPER_W 16
`define BSR_DQ_W 16
`define BSR_PAR_W 2
`define BSR_WORD_W 18
`define BSR_LANES 2
`define BSR_LANE_W 8
`define BSR_BEAT_W 2
`define BSR_DEPTH 262144
`define BSR_FIFO_DEPTH 16

// ----------------------------------------------------------------
// field positions and values
// ----------------------------------------------------------------
`define BSR_PAR_LSB 16
`define BSR_BEAT_ZERO 2'h0
`define BSR_BEAT_STEP 2'h1
`define BSR_LANES_OFF_N 2'h3
`define BSR_BIT_CLR 1'h0
`define BSR_BIT_SET 1'h1
`define BSR_WORD_ZERO 18'h0_0000
`define BSR_ADDR_ZERO 18'h0_0000

`endif

// ===== rtl/burst_sram_pkg.sv
// types for the pipelined burst sram block
package burst_sram_pkg;

`include "burst_sram_regs.svh"

    // burst direction state, gray along idle -> read -> write
    typedef enum logic [1:0] {
        BURST_IDLE  = 2'h0,
        BURST_READ  = 2'h1,
        BURST_WRITE = 2'h3
    } burst_mode_t;

    // write command waiting for its data
    typedef struct packed {
        logic [`BSR_ADDR_W-1:0] addr;
        logic [`BSR_LANES-1:0] lanes_n;
    } wr_cmd_t;

    // completed write on its way to the array
    typedef struct packed {
        logic [`BSR_ADDR_W-1:0] addr;
        logic [`BSR_LANES-1:0] lanes_n;
        logic [`BSR_WORD_W-1:0] word;
    } wr_entry_t;

endpackage

// ===== rtl/stream_fifo.sv
// parameterised valid/ready fifo
`timescale 1ns/1ps

module stream_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // fill side
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    // drain side
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);

    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store_q [DEPTH];
    logic [PW:0] wr_ptr_q;
    logic [PW:0] rd_ptr_q;
    logic full;
    logic empty;
    logic push;
    logic pop;

    assign empty = (wr_ptr_q == rd_ptr_q);
    assign full = (wr_ptr_q[PW] != rd_ptr_q[PW]) &&
                  (wr_ptr_q[PW-1:0] == rd_ptr_q[PW-1:0]);
    assign push = in_valid_in && !full;
    assign pop = out_ready_in && !empty;
    assign in_ready_out = !full;
    assign out_valid_out = !empty;
    assign out_data_out = store_q[rd_ptr_q[PW-1:0]];

    always_ff @(posedge clk_in) begin
        if (push) begin
            store_q[wr_ptr_q[PW-1:0]] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            wr_ptr_q <= '0;
        end else if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rd_ptr_q <= '0;
        end else if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
        end
    end

endmodule // stream_fifo

// ===== rtl/pipelined_burst_sram_control.sv
// pipelined burst sram: command decode, burst counter, data pipeline
//
// Operation
// - inputs sampled on rising edge; read data leaves through output flops
// - clock qualify high: edge ignored, command, burst and pipeline state held; drive enable and order syncs still sample
// - read starts: all selects active, write strobe high, load; address latched
// - read data driven after the qualified edge following address capture
// - read data only driven if output drive enable was low two edges earlier
// - any command accepted on the edge right after a read
// - deselect pipelined: outputs float after the following qualified edge
// - burst counter serves up to four beats from one loaded address
// - burst order input low linear, high interleaved
// - counter acts on two low address bits, wraps within group
// - advance high steps the burst, ignoring selects and write strobe
// - direction captured at burst start, kept for every beat
// - write starts: all selects active, strobe low; address and lanes latched
// - edge after write command floats outputs regardless of drive enable
// - write data captured at second qualified edge after the command
// - only lanes with active byte select are updated
// - next beat address: interleaved flips bits, linear adds modulo four
// - lane 0 is data 7..0 plus parity 0, lane 1 data 15..8 plus parity 1
// - outputs float in the first clock after leaving deselect
// - after reset deselected with data and parity floating
`timescale 1ns/1ps
`include "burst_sram_regs.svh"

module pipelined_burst_sram_control (
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // command pins
    input wire logic clock_qualify_n_in,
    input wire logic chip_select_a_n_in,
    input wire logic chip_select_b_in,
    input wire logic chip_select_c_n_in,
    input wire logic advance_or_load_in,
    input wire logic write_strobe_n_in,
    input wire logic [`BSR_LANES-1:0] byte_lane_select_n_in,
    input wire logic [`BSR_ADDR_W-1:0] address_in,
    // straps and asynchronous controls
    input wire logic burst_order_in,
    input wire logic output_drive_enable_n_in,
    // data lines
    input wire logic [`BSR_DQ_W-1:0] data_lines_in,
    output logic [`BSR_DQ_W-1:0] data_lines_out,
    output logic data_lines_oe_out,
    // parity lines
    input wire logic [`BSR_PAR_W-1:0] parity_lines_in,
    output logic [`BSR_PAR_W-1:0] parity_lines_out,
    output logic parity_lines_oe_out,
    // write buffer status
    output logic write_buffer_ready_out
);

    localparam int ENTRY_W = $bits(burst_sram_pkg::wr_entry_t);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------

    function automatic logic [`BSR_BEAT_W-1:0] beat_offset(
        input logic [`BSR_BEAT_W-1:0] start,
        input logic [`BSR_BEAT_W-1:0] beat,
        input logic interleaved
    );
        logic [`BSR_BEAT_W-1:0] res;
        res = start + beat;
        if (interleaved) begin
            res = start ^ beat;
        end
        return res;
    endfunction

    // overlay selected lanes of a new word on an old one
    function automatic logic [`BSR_WORD_W-1:0] lane_merge(
        input logic [`BSR_WORD_W-1:0] old_word,
        input logic [`BSR_WORD_W-1:0] new_word,
        input logic [`BSR_LANES-1:0] lanes_n
    );
        logic [`BSR_WORD_W-1:0] res;
        res = old_word;
        for (int i = 0; i < `BSR_LANES; i++) begin
            if (!lanes_n[i]) begin
                res[i*`BSR_LANE_W +: `BSR_LANE_W] =
                    new_word[i*`BSR_LANE_W +: `BSR_LANE_W];
                res[`BSR_PAR_LSB + i] = new_word[`BSR_PAR_LSB + i];
            end
        end
        return res;
    endfunction

    // ----------------------------------------------------------------
    // asynchronous and strap inputs
    // ----------------------------------------------------------------
    logic oe_n_meta_q;
    logic oe_n_sync_q;
    logic order_meta_q;
    logic order_sync_q;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            oe_n_meta_q <= `BSR_BIT_SET;
            oe_n_sync_q <= `BSR_BIT_SET;
        end else begin
            oe_n_meta_q <= output_drive_enable_n_in;
            oe_n_sync_q <= oe_n_meta_q;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            order_meta_q <= `BSR_BIT_SET;
            order_sync_q <= `BSR_BIT_SET;
        end else begin
            order_meta_q <= burst_order_in;
            order_sync_q <= order_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    logic qual;
    logic all_sel;
    burst_sram_pkg::burst_mode_t mode_q;
    burst_sram_pkg::burst_mode_t acc_mode;
    logic [`BSR_UPPER_W-1:0] upper_q;
    logic [`BSR_BEAT_W-1:0] start_q;
    logic [`BSR_BEAT_W-1:0] beat_q;
    logic [`BSR_BEAT_W-1:0] beat_next;
    logic [`BSR_ADDR_W-1:0] acc_addr;

    // edge recognised only with qualify low
    assign qual = !clock_qualify_n_in;
    assign all_sel = !chip_select_a_n_in && chip_select_b_in &&
                     !chip_select_c_n_in;
    assign beat_next = beat_q + `BSR_BEAT_STEP;

    always_comb begin
        acc_mode = burst_sram_pkg::BURST_IDLE;
        acc_addr = {upper_q, beat_offset(start_q, beat_next, order_sync_q)};
        if (advance_or_load_in) begin
            acc_mode = mode_q;
        end else if (all_sel) begin
            acc_addr = address_in;
            if (write_strobe_n_in) begin
                acc_mode = burst_sram_pkg::BURST_READ;
            end else begin
                acc_mode = burst_sram_pkg::BURST_WRITE;
            end
        end
    end

    // ----------------------------------------------------------------
    // burst state
    // ----------------------------------------------------------------

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            mode_q <= burst_sram_pkg::BURST_IDLE;
        end else if (qual && !advance_or_load_in) begin
            mode_q <= acc_mode;
        end
    end

    // two-bit beat counter wraps in group
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            beat_q <= `BSR_BEAT_ZERO;
        end else if (qual) begin
            if (advance_or_load_in) begin
                beat_q <= beat_next;
            end else begin
                beat_q <= `BSR_BEAT_ZERO;
            end
        end
    end

    // upper bits and start offset held during burst
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            upper_q <= '0;
            start_q <= `BSR_BEAT_ZERO;
        end else if (qual && !advance_or_load_in && all_sel) begin
            upper_q <= address_in[`BSR_ADDR_W-1:`BSR_BEAT_W];
            start_q <= address_in[`BSR_BEAT_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // read pipeline
    // ----------------------------------------------------------------
    logic rd_v_q;
    logic [`BSR_ADDR_W-1:0] rd_addr_q;

    // a new command every qualified edge
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rd_v_q <= `BSR_BIT_CLR;
            rd_addr_q <= `BSR_ADDR_ZERO;
        end else if (qual) begin
            rd_v_q <= (acc_mode == burst_sram_pkg::BURST_READ);
            rd_addr_q <= acc_addr;
        end
    end

    // ----------------------------------------------------------------
    // write pipeline
    // ----------------------------------------------------------------
    logic wr1_v_q;
    logic wr2_v_q;
    burst_sram_pkg::wr_cmd_t wr1_q;
    burst_sram_pkg::wr_cmd_t wr2_q;
    burst_sram_pkg::wr_entry_t push_entry;
    logic push_v;
    logic push_ready;

    // address and lane selects captured with command
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            wr1_v_q <= `BSR_BIT_CLR;
            wr1_q <= '0;
        end else if (qual) begin
            wr1_v_q <= (acc_mode == burst_sram_pkg::BURST_WRITE);
            wr1_q.addr <= acc_addr;
            wr1_q.lanes_n <= byte_lane_select_n_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            wr2_v_q <= `BSR_BIT_CLR;
            wr2_q <= '0;
        end else if (qual) begin
            wr2_v_q <= wr1_v_q;
            wr2_q <= wr1_q;
        end
    end

    // data taken at second qualified edge after command
    assign push_v = qual && wr2_v_q;
    assign push_entry.addr = wr2_q.addr;
    assign push_entry.lanes_n = wr2_q.lanes_n;
    assign push_entry.word = {parity_lines_in, data_lines_in};

    // ----------------------------------------------------------------
    // write buffer and array
    // ----------------------------------------------------------------
    logic [`BSR_WORD_W-1:0] mem [`BSR_DEPTH];
    logic head_v;
    logic [ENTRY_W-1:0] head_bits;
    burst_sram_pkg::wr_entry_t head;

    assign head = burst_sram_pkg::wr_entry_t'(head_bits);

    // drain stalls while the clock is unqualified
    stream_fifo #(
        .WIDTH(ENTRY_W),
        .DEPTH(`BSR_FIFO_DEPTH)
    ) u_wr_fifo (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .in_valid_in(push_v),
        .in_data_in(push_entry),
        .in_ready_out(push_ready),
        .out_valid_out(head_v),
        .out_data_out(head_bits),
        .out_ready_in(qual)
    );

    // per-lane update of the array word
    always_ff @(posedge clk_in) begin
        if (qual && head_v) begin
            for (int i = 0; i < `BSR_LANES; i++) begin
                if (!head.lanes_n[i]) begin
                    mem[head.addr][i*`BSR_LANE_W +: `BSR_LANE_W] <=
                        head.word[i*`BSR_LANE_W +: `BSR_LANE_W];
                    mem[head.addr][`BSR_PAR_LSB + i] <=
                        head.word[`BSR_PAR_LSB + i];
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            write_buffer_ready_out <= `BSR_BIT_SET;
        end else begin
            write_buffer_ready_out <= push_ready;
        end
    end

    // ----------------------------------------------------------------
    // read data with forwarding of pending writes
    // ----------------------------------------------------------------
    logic [`BSR_WORD_W-1:0] rd_word;

    // older buffered write first, then the one landing now
    always_comb begin
        rd_word = mem[rd_addr_q];
        if (head_v && head.addr == rd_addr_q) begin
            rd_word = lane_merge(rd_word, head.word, head.lanes_n);
        end
        if (push_v && wr2_q.addr == rd_addr_q) begin
            rd_word = lane_merge(rd_word, push_entry.word, wr2_q.lanes_n);
        end
    end

    // ----------------------------------------------------------------
    // output register and drive
    // ----------------------------------------------------------------
    logic drive_q;
    logic drive_next;

    // drive only in the read data cycle
    assign drive_next = qual ? rd_v_q : drive_q;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            drive_q <= `BSR_BIT_CLR;
        end else begin
            drive_q <= drive_next;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            data_lines_oe_out <= `BSR_BIT_CLR;
            parity_lines_oe_out <= `BSR_BIT_CLR;
        end else begin
            data_lines_oe_out <= drive_next && !oe_n_sync_q;
            parity_lines_oe_out <= drive_next && !oe_n_sync_q;
        end
    end

    // data registered one qualified edge after capture
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            data_lines_out <= '0;
            parity_lines_out <= '0;
        end else if (qual && rd_v_q) begin
            data_lines_out <= rd_word[`BSR_DQ_W-1:0];
            parity_lines_out <= rd_word[`BSR_PAR_LSB +: `BSR_PAR_W];
        end
    end

endmodule // pipelined_burst_sram_control

// ===== testbench/burst_sram_checker.sv
// port assertions for the pipelined burst sram control
`timescale 1ns/1ps
`include "burst_sram_regs.svh"

module burst_sram_checker (
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // command pins
    input wire logic clock_qualify_n_in,
    input wire logic chip_select_a_n_in,
    input wire logic chip_select_b_in,
    input wire logic chip_select_c_n_in,
    input wire logic advance_or_load_in,
    input wire logic write_strobe_n_in,
    input wire logic output_drive_enable_n_in,
    // outputs
    input wire logic [`BSR_DQ_W-1:0] data_lines_out,
    input wire logic data_lines_oe_out,
    input wire logic parity_lines_oe_out
);
    logic sel;
    logic qual;
    logic odn;

    assign sel = !chip_select_a_n_in && chip_select_b_in && !chip_select_c_n_in;
    assign qual = !clock_qualify_n_in;
    assign odn = output_drive_enable_n_in;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);

    // ----------------------------------------------------------------
    // sequences and properties
    // ----------------------------------------------------------------
    sequence s_read;
        qual && sel && !advance_or_load_in && write_strobe_n_in
            && !odn && !$past(odn);
    endsequence
    property p_read_lat;
        s_read ##1 (qual && !odn) |=> data_lines_oe_out;
    endproperty
    property p_b2b;
        s_read ##1 s_read ##1 (qual && !odn) |-> data_lines_oe_out [*2];
    endproperty
    property p_adv;
        s_read ##1 (qual && advance_or_load_in && !sel && !write_strobe_n_in
            && !odn) ##1 (qual && !odn) |-> data_lines_oe_out [*2];
    endproperty
    property p_write_float;
        qual && sel && !advance_or_load_in && !write_strobe_n_in ##1 qual
            |=> !data_lines_oe_out;
    endproperty
    property p_desel;
        qual && !sel && !advance_or_load_in ##1 qual |=> !data_lines_oe_out;
    endproperty
    property p_hold;
        clock_qualify_n_in && !srst_in
            |=> $stable(data_lines_out) && $stable(data_lines_oe_out);
    endproperty
    property p_oe_mask;
        odn [*4] |-> !data_lines_oe_out;
    endproperty
    property p_reset_float;
        $fell(srst_in) |-> !data_lines_oe_out && !parity_lines_oe_out;
    endproperty

    // ----------------------------------------------------------------
    // assertions and covers
    // ----------------------------------------------------------------
    a_read_lat: assert property (p_read_lat)
        else $error("read data not driven one edge after load");
    a_b2b: assert property (p_b2b)
        else $error("back to back reads not both driven");
    a_adv: assert property (p_adv)
        else $error("advance did not continue the read burst");
    a_write_float: assert property (p_write_float)
        else $error("outputs driven in write data cycle");
    a_desel: assert property (p_desel)
        else $error("outputs driven after deselect");
    a_hold: assert property (p_hold)
        else $error("outputs changed on an ignored edge");
    a_oe_mask: assert property (p_oe_mask)
        else $error("outputs driven with drive enable high");
    a_reset_float: assert property (p_reset_float)
        else $error("outputs driven after reset");
    c_read: cover property (s_read);
    c_write: cover property (qual && sel && !write_strobe_n_in);
    c_hold: cover property (clock_qualify_n_in [*3]);
endmodule // burst_sram_checker

// ===== testbench/sram_master_model.sv
// bus master model driving the burst sram pins
`timescale 1ns/1ps
`include "burst_sram_regs.svh"

module sram_master_model (
    // clock
    input wire logic clk_in,
    // command pins
    output logic clock_qualify_n_out,
    output logic chip_select_a_n_out,
    output logic chip_select_b_out,
    output logic chip_select_c_n_out,
    output logic advance_or_load_out,
    output logic write_strobe_n_out,
    output logic [`BSR_LANES-1:0] byte_lane_select_n_out,
    output logic [`BSR_ADDR_W-1:0] address_out,
    output logic output_drive_enable_n_out,
    // write data
    output logic [`BSR_DQ_W-1:0] data_lines_out,
    output logic [`BSR_PAR_W-1:0] parity_lines_out
);
    logic wmode;
    logic v1, v2;
    logic [`BSR_WORD_W-1:0] d1, d2;

    initial begin
        clock_qualify_n_out = 1'h0;
        {chip_select_a_n_out, chip_select_b_out, chip_select_c_n_out} = 3'h5;
        advance_or_load_out = 1'h0;
        write_strobe_n_out = 1'h1;
        byte_lane_select_n_out = 2'h3;
        address_out = `BSR_ADDR_ZERO;
        output_drive_enable_n_out = 1'h0;
        {parity_lines_out, data_lines_out} = `BSR_WORD_ZERO;
        {wmode, v1, v2} = 3'h0;
        {d1, d2} = {2{`BSR_WORD_ZERO}};
    end

    task automatic op(input logic sel, input logic adv, input logic we_n,
                      input logic [`BSR_LANES-1:0] ln_n,
                      input logic [`BSR_ADDR_W-1:0] a,
                      input logic [`BSR_WORD_W-1:0] d);
        @(negedge clk_in);
        if (!adv) begin
            wmode = sel && !we_n;
        end
        clock_qualify_n_out = 1'h0;
        {chip_select_a_n_out, chip_select_b_out, chip_select_c_n_out} =
            sel ? 3'h2 : 3'h5;
        advance_or_load_out = adv;
        write_strobe_n_out = we_n;
        byte_lane_select_n_out = ln_n;
        address_out = a;
        {parity_lines_out, data_lines_out} =
            v2 ? d2 : ~{parity_lines_out, data_lines_out};
        {v2, d2} = {v1, d1};
        {v1, d1} = {wmode, d};
        @(posedge clk_in);
        #1;
    endtask

    task automatic hold(input int n);
        @(negedge clk_in);
        clock_qualify_n_out = 1'h1;
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic set_oe_n(input logic v);
        @(negedge clk_in);
        output_drive_enable_n_out = v;
    endtask
endmodule // sram_master_model

// ===== testbench/pipelined_burst_sram_control_test.sv
// self-checking bench for the pipelined burst sram control
`timescale 1ns/1ps
`include "burst_sram_regs.svh"

module pipelined_burst_sram_control_test;
    logic clk_in, srst_in, burst_order, cq_n, cs_a_n, cs_b, cs_c_n;
    logic adv, we_n, oe_n, dq_oe, dp_oe, buf_rdy;
    logic [1:0] lanes_n, dp, q_dp;
    logic [15:0] dq, q_dq;
    logic [17:0] addr;
    int miscompares = 0;
    int n_tests = 0;

    sram_master_model u_master (
        .clk_in(clk_in), .clock_qualify_n_out(cq_n),
        .chip_select_a_n_out(cs_a_n), .chip_select_b_out(cs_b),
        .chip_select_c_n_out(cs_c_n), .advance_or_load_out(adv),
        .write_strobe_n_out(we_n), .byte_lane_select_n_out(lanes_n),
        .address_out(addr), .output_drive_enable_n_out(oe_n),
        .data_lines_out(dq), .parity_lines_out(dp)
    );
    pipelined_burst_sram_control dut (
        .clk_in(clk_in), .srst_in(srst_in), .clock_qualify_n_in(cq_n),
        .chip_select_a_n_in(cs_a_n), .chip_select_b_in(cs_b),
        .chip_select_c_n_in(cs_c_n), .advance_or_load_in(adv),
        .write_strobe_n_in(we_n), .byte_lane_select_n_in(lanes_n),
        .address_in(addr), .burst_order_in(burst_order),
        .output_drive_enable_n_in(oe_n), .data_lines_in(dq),
        .data_lines_out(q_dq), .data_lines_oe_out(dq_oe),
        .parity_lines_in(dp), .parity_lines_out(q_dp),
        .parity_lines_oe_out(dp_oe), .write_buffer_ready_out(buf_rdy)
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic compare(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic desel();
        u_master.op(1'h0, 1'h0, 1'h1, 2'h3, `BSR_ADDR_ZERO, `BSR_WORD_ZERO);
    endtask
    task automatic wr(input logic [17:0] a, input logic [1:0] ln,
                      input logic [17:0] d);
        u_master.op(1'h1, 1'h0, 1'h0, ln, a, d);
    endtask
    task automatic rd_ld(input logic [17:0] a);
        u_master.op(1'h1, 1'h0, 1'h1, 2'h3, a, `BSR_WORD_ZERO);
    endtask
    task automatic rd(input logic [17:0] a, input logic [17:0] exp);
        rd_ld(a);
        compare("oe at load", 32'h0, 32'(dq_oe));
        desel();
        compare("read word", 32'(exp), 32'({q_dp, q_dq}));
        compare("read oe", 32'h3, 32'({dp_oe, dq_oe}));
    endtask
    function automatic logic [1:0] beat(logic [1:0] s, logic [1:0] j,
                                        logic il);
        return il ? s ^ j : s + j;
    endfunction

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic sc_reset();
        compare("oe after reset", 32'h0, 32'({dp_oe, dq_oe}));
        compare("ready after reset", 32'h1, 32'(buf_rdy));
    endtask
    task automatic sc_b2b();
        wr(18'h0_0105, 2'h0, 18'h2_a5c3);
        rd_ld(18'h0_0105);
        compare("oe after write", 32'h0, 32'(dq_oe));
        rd_ld(18'h0_0105);
        compare("first word", 32'h2_a5c3, 32'({q_dp, q_dq}));
        desel();
        compare("second word", 32'h2_a5c3, 32'({q_dp, q_dq}));
        compare("second oe", 32'h1, 32'(dq_oe));
    endtask
    task automatic sc_lanes();
        logic [17:0] m;
        for (int i = 0; i < 4; i++) begin
            m = {~i[1], ~i[0], {8{~i[1]}}, {8{~i[0]}}};
            wr(18'h0_0200, 2'h0, 18'h1_5555);
            wr(18'h0_0200, 2'(i), 18'h2_aaaa);
            rd(18'h0_0200, (18'h2_aaaa & m) | (18'h1_5555 & ~m));
        end
    endtask
    task automatic sc_burst(input logic il);
        logic [17:0] sh [4];
        logic [17:0] d;
        d = {il, 17'h0_4c00};
        @(negedge clk_in);
        burst_order = il;
        repeat (3) desel();
        for (int j = 0; j < 4; j++) begin
            u_master.op(j == 0, j != 0, j != 0, 2'h0,
                j == 0 ? 18'h0_48d2 : `BSR_ADDR_ZERO, d + 18'(j));
            sh[beat(2'h2, 2'(j), il)] = d + 18'(j);
        end
        desel();
        for (int k = 0; k < 4; k++) begin
            rd({16'h1234, 2'(k)}, sh[k]);
        end
        for (int j = 0; j < 4; j++) begin
            u_master.op(j == 0, j != 0, j == 0, 2'h3,
                j == 0 ? 18'h0_48d1 : `BSR_ADDR_ZERO, `BSR_WORD_ZERO);
            if (j > 0) begin
                compare("beat", 32'(sh[beat(2'h1, 2'(j - 1), il)]),
                    32'({q_dp, q_dq}));
            end
        end
        desel();
        compare("last beat", 32'(sh[beat(2'h1, 2'h3, il)]),
            32'({q_dp, q_dq}));
    endtask
    task automatic sc_suspend();
        rd_ld(18'h0_0105);
        u_master.hold(3);
        compare("oe in suspend", 32'h0, 32'(dq_oe));
        desel();
        compare("word after suspend", 32'h2_a5c3, 32'({q_dp, q_dq}));
        u_master.hold(2);
        compare("oe held", 32'h1, 32'(dq_oe));
        compare("word held", 32'h2_a5c3, 32'({q_dp, q_dq}));
        desel();
        compare("oe after deselect", 32'h0, 32'(dq_oe));
    endtask
    task automatic sc_oe();
        u_master.set_oe_n(1'h1);
        repeat (3) desel();
        rd_ld(18'h0_0105);
        desel();
        compare("oe masked", 32'h0, 32'({dp_oe, dq_oe}));
        u_master.set_oe_n(1'h0);
        repeat (3) desel();
    endtask

    // ----------------------------------------------------------------
    // clock, reset, sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        clk_in = 1'h0;
        forever #2.5 clk_in = ~clk_in;
    end
    initial begin
        srst_in = 1'h1;
        burst_order = 1'h0;
        repeat (3) @(posedge clk_in);
        @(negedge clk_in);
        srst_in = 1'h0;
        #1;
        sc_reset();
        sc_b2b();
        sc_lanes();
        sc_burst(1'h0);
        sc_burst(1'h1);
        sc_suspend();
        sc_oe();
        give_verdict();
    end
    initial begin
        repeat (5000) @(posedge clk_in);
        miscompares++;
        give_verdict();
    end
endmodule // pipelined_burst_sram_control_test

bind pipelined_burst_sram_control burst_sram_checker u_chk (
    .clk_in(clk_in), .srst_in(srst_in),
    .clock_qualify_n_in(clock_qualify_n_in),
    .chip_select_a_n_in(chip_select_a_n_in),
    .chip_select_b_in(chip_select_b_in),
    .chip_select_c_n_in(chip_select_c_n_in),
    .advance_or_load_in(advance_or_load_in),
    .write_strobe_n_in(write_strobe_n_in),
    .output_drive_enable_n_in(output_drive_enable_n_in),
    .data_lines_out(data_lines_out), .data_lines_oe_out(data_lines_oe_out),
    .parity_lines_oe_out(parity_lines_oe_out)
);
